// >>> verilog/ulf_consts.svh
`ifndef ULF_CONSTS_SVH
`define ULF_CONSTS_SVH

`define ULF_ADDR_W           8
`define ULF_OFS_FLAGS        8'h1c
`define ULF_OFS_STICKY       8'h20
`define ULF_OFS_PORT_MASKS   8'h24
`define ULF_OFS_FRAME        8'h28
`define ULF_OFS_PID          8'h2c
`define ULF_OFS_ENDPOINT     8'h30
`define ULF_OFS_EP_MARK      8'h34
`define ULF_OFS_OTG_MASK     8'h38
`define ULF_OFS_PWR_SIG      8'h3c
`define ULF_OFS_PHY_CTRL     8'h40

`define ULF_NFLAGS           7
`define ULF_FLAG_TOKEN       6
`define ULF_FLAG_SE0         5
`define ULF_FLAG_K           4
`define ULF_FLAG_J           3
`define ULF_FLAG_CRC16       2
`define ULF_FLAG_RXACTIVE    1
`define ULF_FLAG_RXERROR     0

`define ULF_MASK_A_LSB       0
`define ULF_MASK_B_LSB       8
`define ULF_MASK_C_LSB       16
`define ULF_FRAME_W          11
`define ULF_PWR_VALID_BIT    8
`define ULF_PD_DIS_BIT       18
`define ULF_RES_SE0_BIT      13
`define ULF_RES_K_BIT        12
`define ULF_FILT_LSB         8
`define ULF_SUSP_EN_BIT      7
`define ULF_CONF_LSB         4
`define ULF_EP_VALID_BIT     4
`define ULF_EP_MARK_OR       5'h10

`define ULF_FILT_CNT_W       16
`define ULF_RESET_WORD       32'h0000_0000

`endif

// >>> verilog/ulf_pkg.sv
package ulf_pkg;
  typedef logic [1:0]  line_state_t;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  apb_addr_t;
  typedef logic [6:0]  flag_vec_t;
  typedef enum logic [1:0] {
    LS_SE0 = 2'b00,
    LS_J   = 2'b01,
    LS_K   = 2'b10,
    LS_SE1 = 2'b11
  } line_sym_t;
  typedef enum {
    RS_AWAKE,
    RS_SUSPENDED
  } resume_state_t;
endpackage

// >>> verilog/line_filter_if.sv
interface line_filter_if;
  logic [1:0] raw;
  logic [3:0] log2_cycles;
  logic [1:0] filt;
  modport filter (input raw, input log2_cycles, output filt);
  modport user   (output raw, output log2_cycles, input filt);
endinterface

// >>> verilog/line_state_filter.sv
`include "ulf_consts.svh"
module line_state_filter (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  line_filter_if.filter     lf
);
  import ulf_pkg::*;

  logic [`ULF_FILT_CNT_W-1:0] cnt;
  logic [`ULF_FILT_CNT_W-1:0] next_cnt;
  logic [1:0]                 cand;
  logic [1:0]                 next_cand;
  logic [1:0]                 filt;
  logic [1:0]                 next_filt;
  logic [`ULF_FILT_CNT_W:0]   limit;

  always_comb begin
    limit     = (`ULF_FILT_CNT_W+1)'(1) << lf.log2_cycles;
    next_cnt  = cnt;
    next_cand = cand;
    next_filt = filt;
    if (lf.raw == filt) begin
      next_cnt  = '0;
      next_cand = lf.raw;
    end else if (lf.raw != cand) begin
      // first cycle of a new candidate already counts
      next_cand = lf.raw;
      next_cnt  = `ULF_FILT_CNT_W'(1);
      if (limit == (`ULF_FILT_CNT_W+1)'(1)) begin
        next_filt = lf.raw;
        next_cnt  = '0;
      end
    end else if ({1'b0, cnt} + (`ULF_FILT_CNT_W+1)'(1) >= limit) begin
      // change has held for 2**log2 cycles
      next_filt = lf.raw;
      next_cnt  = '0;
    end else begin
      next_cnt = cnt + `ULF_FILT_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt  <= '0;
      cand <= 2'h1;
      filt <= 2'h1;
    end else begin
      cnt  <= next_cnt;
      cand <= next_cand;
      filt <= next_filt;
    end
  end

  assign lf.filt = filt;
endmodule

// >>> verilog/line_event_flag_unit.sv
`include "ulf_consts.svh"
module line_event_flag_unit (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire ulf_pkg::flag_vec_t stickiness_i,
  input  wire ulf_pkg::flag_vec_t clear_i,
  input  wire logic              packet_start_i,
  input  wire logic              token_ok_i,
  input  wire logic              crc16_fail_i,
  input  wire logic              rx_active_i,
  input  wire logic              rx_error_i,
  input  wire logic [1:0]        line_state_i,
  output ulf_pkg::flag_vec_t     flags_o
);
  import ulf_pkg::*;

  flag_vec_t flags;
  flag_vec_t next_flags;
  flag_vec_t events;

  always_comb begin
    events = '0;
    events[`ULF_FLAG_TOKEN]    = token_ok_i;
    events[`ULF_FLAG_SE0]      = line_state_i == LS_SE0;
    events[`ULF_FLAG_K]        = line_state_i == LS_K;
    events[`ULF_FLAG_J]        = line_state_i == LS_J;
    events[`ULF_FLAG_CRC16]    = crc16_fail_i;
    events[`ULF_FLAG_RXACTIVE] = rx_active_i;
    events[`ULF_FLAG_RXERROR]  = rx_error_i;
    for (int i = 0; i < `ULF_NFLAGS; i++) begin
      if (stickiness_i[i]) begin
        next_flags[i] = (flags[i] & ~clear_i[i]) | events[i];
      end else if (i == `ULF_FLAG_RXACTIVE || i == `ULF_FLAG_RXERROR) begin
        next_flags[i] = events[i];
      end else begin
        next_flags[i] = (flags[i] & ~packet_start_i) | events[i];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  assign flags_o = flags;
endmodule

// >>> verilog/usb_link_frontend.sv
// Notes on behaviour
// - each flag event port is high while any flag picked by its own 8-bit mask field is high.
// - an 11-bit frame counter, read and written by software as a 3-bit and an 8-bit field, resets to zero.
// - the 4-bit identifier of the last received packet is captured into a read-only field reset to zero.
// - the last received endpoint number is copied to a read-only field with a bit marking it valid.
// - one marking bit per endpoint; a marked endpoint is presented on the receive port ORed with 0x10.
// - the pulldown-disable bit turns off pulldowns on both PHY-side 8-bit ports, else they stay on.
// - after an auto-resume caused by SE0 a status bit is set that software clears by writing zero.
// - after an auto-resume caused by a K state a status bit is set that software clears by writing zero.
// - a line-state change passes on only after persisting for 2 to the power of the 4-bit field cycles.
// - with the suspend-resume bit set the controller resumes by itself, else software polls the filtered line state.
// - the three PHY configuration pins follow a 3-bit software field that resets to zero.
// - the flag set holds token decoded, SE0, K, J, CRC16 failure, receive-active and receive-error.
// - flags clear on the next packet (non-sticky receive-active and receive-error follow their pins) unless made sticky, in which case they hold until cleared.
//
// Decided for this implementation: the APB slave port.
`include "ulf_consts.svh"
module usb_link_frontend (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire ulf_pkg::apb_addr_t paddr_i,
  input  wire ulf_pkg::word_t     pwdata_i,
  output ulf_pkg::word_t          prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic [1:0]         line_state_i,
  input  wire logic               receive_active_input_i,
  input  wire logic               receive_error_input_i,
  input  wire logic               packet_start_i,
  input  wire logic               token_ok_i,
  input  wire logic               crc16_fail_i,
  input  wire logic               pid_valid_i,
  input  wire logic [3:0]         pid_i,
  input  wire logic               endpoint_valid_i,
  input  wire logic [3:0]         endpoint_i,
  input  wire logic               frame_valid_i,
  input  wire logic [10:0]        frame_number_i,
  input  wire logic               suspend_i,
  output logic                    flag_event_port_a_o,
  output logic                    flag_event_port_b_o,
  output logic                    flag_event_port_c_o,
  output logic [4:0]              rx_endpoint_o,
  output logic [2:0]              phy_config_pins_o,
  output logic [7:0]              phy_side_port_first_pd_en_o,
  output logic [7:0]              phy_side_port_second_pd_en_o,
  output logic                    resume_o,
  output logic [1:0]              line_state_filt_o,
  output ulf_pkg::word_t          otg_flag_mask_o,
  output logic [7:0]              power_signalling_data_o,
  output logic                    power_signalling_valid_o
);
  import ulf_pkg::*;

  function automatic logic mapped(input apb_addr_t a);
    case (a)
      `ULF_OFS_FLAGS, `ULF_OFS_STICKY, `ULF_OFS_PORT_MASKS, `ULF_OFS_FRAME, `ULF_OFS_PID,
      `ULF_OFS_ENDPOINT, `ULF_OFS_EP_MARK, `ULF_OFS_OTG_MASK, `ULF_OFS_PWR_SIG,
      `ULF_OFS_PHY_CTRL: mapped = 1'b1;
      default:           mapped = 1'b0;
    endcase
  endfunction

  function automatic logic any_masked(input flag_vec_t f, input logic [7:0] m);
    any_masked = |(f & m[`ULF_NFLAGS-1:0]);
  endfunction

  // two-stage synchronisers for the PHY pins
  logic [1:0]    ls_s1;
  logic [1:0]    ls_s2;
  logic          rxa_s1;
  logic          rxa_s2;
  logic          rxe_s1;
  logic          rxe_s2;

  word_t         port_masks;
  word_t         next_port_masks;
  logic [10:0]   frame;
  logic [10:0]   next_frame;
  logic [3:0]    pid;
  logic [3:0]    next_pid;
  logic [3:0]    ep;
  logic [3:0]    next_ep;
  logic          ep_valid;
  logic          next_ep_valid;
  logic [15:0]   ep_mark;
  logic [15:0]   next_ep_mark;
  word_t         otg_mask;
  word_t         next_otg_mask;
  logic [8:0]    pwr_sig;
  logic [8:0]    next_pwr_sig;
  flag_vec_t     sticky;
  flag_vec_t     next_sticky;
  logic          pd_dis;
  logic          next_pd_dis;
  logic          res_se0;
  logic          next_res_se0;
  logic          res_k;
  logic          next_res_k;
  logic [3:0]    filt_log2;
  logic [3:0]    next_filt_log2;
  logic          susp_en;
  logic          next_susp_en;
  logic [2:0]    conf;
  logic [2:0]    next_conf;
  word_t         rdata;
  word_t         next_rdata;
  logic [4:0]    rx_ep;
  logic [4:0]    next_rx_ep;
  resume_state_t rstate;
  resume_state_t next_rstate;
  logic          resume;
  logic          next_resume;

  logic          wr;
  logic          rd_setup;
  flag_vec_t     flags;
  flag_vec_t     flag_clear;
  line_filter_if lf ();

  assign lf.raw         = ls_s2;
  assign lf.log2_cycles = filt_log2;

  line_state_filter u_filter (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .lf     (lf)
  );

  line_event_flag_unit u_flags (
    .mclk_i         (mclk_i),
    .rst_i          (rst_i),
    .stickiness_i   (sticky),
    .clear_i        (flag_clear),
    .packet_start_i (packet_start_i),
    .token_ok_i     (token_ok_i),
    .crc16_fail_i   (crc16_fail_i),
    .rx_active_i    (rxa_s2),
    .rx_error_i     (rxe_s2),
    .line_state_i   (lf.filt),
    .flags_o        (flags)
  );

  // zero-wait access; read data latched in the setup cycle
  assign wr        = psel_i & penable_i & pwrite_i & mapped(paddr_i);
  assign rd_setup  = psel_i & ~penable_i;
  assign pready_o  = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & ~mapped(paddr_i);
  assign flag_clear = (wr && paddr_i == `ULF_OFS_FLAGS) ? pwdata_i[`ULF_NFLAGS-1:0] : '0;

  always_comb begin
    next_rdata = `ULF_RESET_WORD;
    if (rd_setup) begin
      case (paddr_i)
        `ULF_OFS_FLAGS:      next_rdata[`ULF_NFLAGS-1:0] = flags;
        `ULF_OFS_STICKY:     next_rdata[`ULF_NFLAGS-1:0] = sticky;
        `ULF_OFS_PORT_MASKS: next_rdata = port_masks;
        `ULF_OFS_FRAME:      next_rdata[`ULF_FRAME_W-1:0] = frame;
        `ULF_OFS_PID:        next_rdata[3:0] = pid;
        `ULF_OFS_ENDPOINT:   next_rdata[`ULF_EP_VALID_BIT:0] = {ep_valid, ep};
        `ULF_OFS_EP_MARK:    next_rdata[15:0] = ep_mark;
        `ULF_OFS_OTG_MASK:   next_rdata = otg_mask;
        `ULF_OFS_PWR_SIG:    next_rdata[`ULF_PWR_VALID_BIT:0] = pwr_sig;
        `ULF_OFS_PHY_CTRL: begin
          next_rdata[`ULF_PD_DIS_BIT]                 = pd_dis;
          next_rdata[`ULF_RES_SE0_BIT]                = res_se0;
          next_rdata[`ULF_RES_K_BIT]                  = res_k;
          next_rdata[`ULF_FILT_LSB+3:`ULF_FILT_LSB]   = filt_log2;
          next_rdata[`ULF_SUSP_EN_BIT]                = susp_en;
          next_rdata[`ULF_CONF_LSB+2:`ULF_CONF_LSB]   = conf;
        end
        default: next_rdata = `ULF_RESET_WORD;
      endcase
    end else begin
      next_rdata = rdata;
    end
  end

  always_comb begin
    next_port_masks = port_masks;
    next_frame      = frame;
    next_pid        = pid;
    next_ep         = ep;
    next_ep_valid   = ep_valid;
    next_ep_mark    = ep_mark;
    next_otg_mask   = otg_mask;
    next_pwr_sig    = pwr_sig;
    next_sticky     = sticky;
    next_pd_dis     = pd_dis;
    next_res_se0    = res_se0;
    next_res_k      = res_k;
    next_filt_log2  = filt_log2;
    next_susp_en    = susp_en;
    next_conf       = conf;
    next_rx_ep      = rx_ep;
    if (wr) begin
      case (paddr_i)
        `ULF_OFS_STICKY:     next_sticky = pwdata_i[`ULF_NFLAGS-1:0];
        `ULF_OFS_PORT_MASKS: next_port_masks = pwdata_i;
        `ULF_OFS_FRAME:      next_frame = pwdata_i[`ULF_FRAME_W-1:0];
        `ULF_OFS_EP_MARK:    next_ep_mark = pwdata_i[15:0];
        `ULF_OFS_OTG_MASK:   next_otg_mask = pwdata_i;
        `ULF_OFS_PWR_SIG:    next_pwr_sig = pwdata_i[`ULF_PWR_VALID_BIT:0];
        `ULF_OFS_PHY_CTRL: begin
          next_pd_dis    = pwdata_i[`ULF_PD_DIS_BIT];
          next_res_se0   = res_se0 & pwdata_i[`ULF_RES_SE0_BIT];
          next_res_k     = res_k & pwdata_i[`ULF_RES_K_BIT];
          next_filt_log2 = pwdata_i[`ULF_FILT_LSB+3:`ULF_FILT_LSB];
          next_susp_en   = pwdata_i[`ULF_SUSP_EN_BIT];
          next_conf      = pwdata_i[`ULF_CONF_LSB+2:`ULF_CONF_LSB];
        end
        default: next_conf = conf;
      endcase
    end
    // decoder updates win over a software write in the same cycle
    if (frame_valid_i) begin
      next_frame = frame_number_i;
    end
    if (pid_valid_i) begin
      next_pid = pid_i;
    end
    if (endpoint_valid_i) begin
      next_ep       = endpoint_i;
      next_ep_valid = 1'b1;
      next_rx_ep    = ep_mark[endpoint_i] ? ({1'b0, endpoint_i} | `ULF_EP_MARK_OR) : {1'b0, endpoint_i};
    end
    // resume flags: hardware set beats a software clear
    if (rstate == RS_SUSPENDED && susp_en && lf.filt == LS_SE0) begin
      next_res_se0 = 1'b1;
    end
    if (rstate == RS_SUSPENDED && susp_en && lf.filt == LS_K) begin
      next_res_k = 1'b1;
    end
  end

  always_comb begin
    next_rstate = rstate;
    next_resume = 1'b0;
    case (rstate)
      RS_AWAKE: begin
        if (suspend_i && susp_en) begin
          next_rstate = RS_SUSPENDED;
        end
      end
      RS_SUSPENDED: begin
        if (!susp_en) begin
          next_rstate = RS_AWAKE;
        end else if (lf.filt == LS_SE0 || lf.filt == LS_K) begin
          next_rstate = RS_AWAKE;
          next_resume = 1'b1;
        end
      end
      default: next_rstate = RS_AWAKE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ls_s1      <= 2'h1;
      ls_s2      <= 2'h1;
      rxa_s1     <= 1'b0;
      rxa_s2     <= 1'b0;
      rxe_s1     <= 1'b0;
      rxe_s2     <= 1'b0;
      port_masks <= `ULF_RESET_WORD;
      frame      <= '0;
      pid        <= '0;
      ep         <= '0;
      ep_valid   <= 1'b0;
      ep_mark    <= '0;
      otg_mask   <= `ULF_RESET_WORD;
      pwr_sig    <= '0;
      sticky     <= '0;
      pd_dis     <= 1'b0;
      res_se0    <= 1'b0;
      res_k      <= 1'b0;
      filt_log2  <= '0;
      susp_en    <= 1'b0;
      conf       <= '0;
      rdata      <= `ULF_RESET_WORD;
      rx_ep      <= '0;
      rstate     <= RS_AWAKE;
      resume     <= 1'b0;
    end else begin
      ls_s1      <= line_state_i;
      ls_s2      <= ls_s1;
      rxa_s1     <= receive_active_input_i;
      rxa_s2     <= rxa_s1;
      rxe_s1     <= receive_error_input_i;
      rxe_s2     <= rxe_s1;
      port_masks <= next_port_masks;
      frame      <= next_frame;
      pid        <= next_pid;
      ep         <= next_ep;
      ep_valid   <= next_ep_valid;
      ep_mark    <= next_ep_mark;
      otg_mask   <= next_otg_mask;
      pwr_sig    <= next_pwr_sig;
      sticky     <= next_sticky;
      pd_dis     <= next_pd_dis;
      res_se0    <= next_res_se0;
      res_k      <= next_res_k;
      filt_log2  <= next_filt_log2;
      susp_en    <= next_susp_en;
      conf       <= next_conf;
      rdata      <= next_rdata;
      rx_ep      <= next_rx_ep;
      rstate     <= next_rstate;
      resume     <= next_resume;
    end
  end

  assign prdata_o                     = rdata;
  assign flag_event_port_a_o          = any_masked(flags, port_masks[`ULF_MASK_A_LSB+7:`ULF_MASK_A_LSB]);
  assign flag_event_port_b_o          = any_masked(flags, port_masks[`ULF_MASK_B_LSB+7:`ULF_MASK_B_LSB]);
  assign flag_event_port_c_o          = any_masked(flags, port_masks[`ULF_MASK_C_LSB+7:`ULF_MASK_C_LSB]);
  assign rx_endpoint_o                = rx_ep;
  assign phy_config_pins_o            = conf;
  assign phy_side_port_first_pd_en_o  = {8{~pd_dis}};
  assign phy_side_port_second_pd_en_o = {8{~pd_dis}};
  assign resume_o                     = resume;
  assign line_state_filt_o            = lf.filt;
  assign otg_flag_mask_o              = otg_mask;
  assign power_signalling_data_o      = pwr_sig[7:0];
  assign power_signalling_valid_o     = pwr_sig[`ULF_PWR_VALID_BIT];
endmodule

// >>> test/usb_link_frontend_checker.sv
module usb_link_frontend_checker (
  input wire logic               mclk_i,
  input wire logic               rst_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pwrite_i,
  input wire ulf_pkg::apb_addr_t paddr_i,
  input wire ulf_pkg::word_t     pwdata_i,
  input wire ulf_pkg::word_t     prdata_o,
  input wire logic               pready_o,
  input wire logic               pslverr_o,
  input wire logic               endpoint_valid_i,
  input wire logic [3:0]         endpoint_i,
  input wire logic [4:0]         rx_endpoint_o,
  input wire logic [2:0]         phy_config_pins_o,
  input wire logic [7:0]         phy_side_port_first_pd_en_o,
  input wire logic [7:0]         phy_side_port_second_pd_en_o,
  input wire logic               resume_o,
  input wire logic [1:0]         line_state_filt_o,
  input wire ulf_pkg::word_t     otg_flag_mask_o,
  input wire logic [7:0]         power_signalling_data_o,
  input wire logic               power_signalling_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ulf_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic acc;
  logic wr;
  logic unm;
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign unm = paddr_i < 8'h1c || paddr_i > 8'h40 || paddr_i[1:0] != 2'b00;

  a_reset_clean: assert property
    ($fell(rst_i) |-> phy_config_pins_o == 3'h0 && rx_endpoint_o == 5'h0 && otg_flag_mask_o == 32'h0)
    else $error("outputs not cleared by reset");
  a_conf_write: assert property
    (wr && paddr_i == 8'h40 |=> {phy_config_pins_o, 4'h0} == 7'($past(pwdata_i) & 32'h70))
    else $error("config pins do not follow write");
  a_pd_follow: assert property
    (wr && paddr_i == 8'h40 |=>
      phy_side_port_first_pd_en_o == ((($past(pwdata_i) & 32'h4_0000) != 32'h0) ? 8'h00 : 8'hff))
    else $error("pulldown enable wrong");
  a_pd_pair: assert property
    (phy_side_port_first_pd_en_o == phy_side_port_second_pd_en_o
      && (phy_side_port_first_pd_en_o inside {8'h00, 8'hff}))
    else $error("pulldown ports differ");
  a_otg_write: assert property
    (wr && paddr_i == 8'h38 |=> otg_flag_mask_o == $past(pwdata_i))
    else $error("otg mask not written");
  a_pwr_write: assert property
    (wr && paddr_i == 8'h3c |=>
      {power_signalling_valid_o, power_signalling_data_o} == 9'($past(pwdata_i) & 32'h1ff))
    else $error("power signalling not written");
  a_ep_copy: assert property
    (endpoint_valid_i |=> rx_endpoint_o[3:0] == $past(endpoint_i))
    else $error("endpoint not presented");
  a_ep_hold: assert property
    (!endpoint_valid_i |=> $stable(rx_endpoint_o))
    else $error("endpoint changed without strobe");
  a_resume_once: assert property
    (resume_o |=> !resume_o)
    else $error("resume pulse too long");
  a_resume_cause: assert property
    (resume_o |-> $past(line_state_filt_o) inside {2'b00, 2'b10})
    else $error("resume without se0 or k");
  a_ready_err: assert property
    (acc |-> pready_o && pslverr_o == unm)
    else $error("ready or error response wrong");
  a_unmapped_rd: assert property
    (acc && !pwrite_i && unm |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind usb_link_frontend usb_link_frontend_checker i_chk (
  .mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .endpoint_valid_i, .endpoint_i, .rx_endpoint_o, .phy_config_pins_o,
  .phy_side_port_first_pd_en_o, .phy_side_port_second_pd_en_o, .resume_o, .line_state_filt_o,
  .otg_flag_mask_o, .power_signalling_data_o, .power_signalling_valid_o
);

// >>> test/usb_phy_model.sv
module usb_phy_model (
  input  wire logic       mclk_i,
  input  wire logic [1:0] sym_i,
  input  wire logic       act_i,
  input  wire logic       err_i,
  output logic [1:0]      line_state_o,
  output logic            rx_active_o,
  output logic            rx_error_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins move one edge after the command, as a transceiver would
  always_ff @(posedge mclk_i) begin
    line_state_o <= sym_i;
    rx_active_o  <= act_i;
    rx_error_o   <= err_i;
  end
endmodule

// >>> test/usb_phy_interface_status_ctrl_bench.sv
module usb_phy_interface_status_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ulf_pkg::*;
  logic        clk, rst, psel, pen, pwr, pkt, tok, crc, pidv, epv, frv, susp, act, err, ract, rerr;
  logic        pready, pslverr, pa, pb, pc, res;
  logic [1:0]  sym, ls, lsf;
  logic [2:0]  conf;
  logic [3:0]  pid, ep;
  logic [4:0]  rxep;
  logic [7:0]  pd1;
  logic [10:0] frn;
  apb_addr_t   paddr;
  word_t       pwdata, prdata, v;
  word_t       exp_q[$];
  int          fails, num_checks;
  apb_addr_t   ofs[8] = '{8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40};
  word_t       msk[8] = '{32'hffff_ffff, 32'h7ff, 32'h0, 32'h0, 32'hffff, 32'hffff_ffff, 32'h1ff, 32'h4_0ff0};

  usb_phy_model i_phy (.mclk_i(clk), .sym_i(sym), .act_i(act), .err_i(err), .line_state_o(ls),
    .rx_active_o(ract), .rx_error_o(rerr));
  usb_link_frontend i_dut (
    .mclk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .line_state_i(ls),
    .receive_active_input_i(ract), .receive_error_input_i(rerr), .packet_start_i(pkt), .token_ok_i(tok),
    .crc16_fail_i(crc), .pid_valid_i(pidv), .pid_i(pid), .endpoint_valid_i(epv), .endpoint_i(ep),
    .frame_valid_i(frv), .frame_number_i(frn), .suspend_i(susp), .flag_event_port_a_o(pa),
    .flag_event_port_b_o(pb), .flag_event_port_c_o(pc), .rx_endpoint_o(rxep), .phy_config_pins_o(conf),
    .phy_side_port_first_pd_en_o(pd1), .phy_side_port_second_pd_en_o(), .resume_o(res),
    .line_state_filt_o(lsf), .otg_flag_mask_o(), .power_signalling_data_o(), .power_signalling_valid_o());

  task final_report();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask
  task tmo(input logic ok);
    if (!ok) begin
      fails++;
      final_report();
    end
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task apb(input logic w, input apb_addr_t a, input word_t d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    tmo(k < 16);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input apb_addr_t a, input word_t d);
    apb(1'b1, a, d);
  endtask
  task rd(input apb_addr_t a, input word_t e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // strobes in order: packet start, token, crc16, pid, endpoint, frame, suspend
  task pulse(input logic [6:0] s);
    @(posedge clk);
    {pkt, tok, crc, pidv, epv, frv, susp} <= s;
    pid <= v[3:0];
    ep <= v[7:4];
    frn <= v[18:8];
    @(posedge clk);
    {pkt, tok, crc, pidv, epv, frv, susp} <= 7'h0;
  endtask
  task flg(input logic [2:0] e);
    @(negedge clk);
    chk(32'({pa, pb, pc}), 32'(e), "event ports");
  endtask
  task wait_ls(input logic [1:0] s);
    int k;
    for (k = 0; k < 40 && lsf !== s; k++) @(negedge clk);
    tmo(k < 40);
    chk(32'(lsf), 32'(s), "filtered line");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    final_report();
  end
  // scoreboard: each completed read takes the oldest note
  always @(posedge clk) begin
    if (psel && pen && !pwr && pready === 1'b1) begin
      chk(prdata, exp_q.pop_front(), "read data");
    end
  end

  initial begin
    int n;
    {rst, psel, pen, pwr, pkt, tok, crc, pidv, epv, frv, susp, act, err} = 13'h1000;
    {paddr, pwdata, pid, ep, frn} = '0;
    sym = 2'b01;
    fails = 0;
    num_checks = 0;
    v = $urandom(32'h12d6);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(ofs[i], 32'h0);
    @(negedge clk);
    chk(32'({pd1, conf}), 32'h7f8, "pins after reset");
    done("reset");
    for (int i = 0; i < 8; i++) begin
      v = $urandom();
      wr(ofs[i], v);
      rd(ofs[i], v & msk[i]);
    end
    @(negedge clk);
    chk(32'({pd1, conf}), 32'({v[18] ? 8'h00 : 8'hff, v[6:4]}), "pins follow");
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44, 32'h0);
    rd(8'h00, 32'h0);
    done("registers");
    v = $urandom();
    wr(8'h34, 32'h1 << v[7:4]);
    pulse(7'b0001110);
    @(negedge clk);
    chk(32'(rxep), 32'({1'b1, v[7:4]}), "marked endpoint");
    rd(8'h2c, 32'(v[3:0]));
    rd(8'h30, 32'({1'b1, v[7:4]}));
    rd(8'h28, 32'(v[18:8]));
    v = v ^ 32'h10;
    pulse(7'b0000100);
    @(negedge clk);
    chk(32'(rxep), 32'({1'b0, v[7:4]}), "plain endpoint");
    done("decoder");
    wr(8'h24, 32'h0003_0440);
    pulse(7'b0100000);
    flg(3'b100);
    pulse(7'b1000000);
    flg(3'b000);
    wr(8'h20, 32'h44);
    pulse(7'b0110000);
    pulse(7'b1000000);
    flg(3'b110);
    wr(8'h1c, 32'h40);
    flg(3'b010);
    @(posedge clk);
    act <= 1'b1;
    tick(6);
    flg(3'b011);
    @(posedge clk);
    act <= 1'b0;
    err <= 1'b1;
    tick(6);
    flg(3'b011);
    done("flags");
    wr(8'h40, 32'h280);
    @(posedge clk);
    sym <= 2'b10;
    tick(3);
    sym <= 2'b01;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      chk(32'(lsf), 32'h1, "short glitch");
    end
    @(posedge clk);
    sym <= 2'b10;
    tick(4);
    sym <= 2'b01;
    wait_ls(2'b10);
    wait_ls(2'b01);
    done("filter");
    for (int i = 0; i < 2; i++) begin
      pulse(7'b0000001);
      sym <= (i == 1) ? 2'b10 : 2'b00;
      for (n = 0; n < 40 && res !== 1'b1; n++) @(negedge clk);
      tmo(n < 40);
      @(posedge clk);
      sym <= 2'b01;
      wait_ls(2'b01);
      rd(8'h40, (i == 1) ? 32'h1280 : 32'h2280);
      wr(8'h40, 32'h280);
      rd(8'h40, 32'h280);
    end
    wr(8'h40, 32'h200);
    pulse(7'b0000001);
    sym <= 2'b00;
    wait_ls(2'b00);
    rd(8'h40, 32'h200);
    rd(8'h1c, 32'h3d);
    rd(8'h20, 32'h44);
    done("resume");
    final_report();
  end
endmodule
